// [hdl/protection_latch_supervisor.sv]
// Protection, latch-off and release supervisor of the flyback controller
//
// The implementer's own choices: the address map and the plain strobed port.
module protection_latch_supervisor
   import latch_sup_pkg::*;
#(
   parameter int FAULT_CYC = 1000,
   parameter int AUTOREC_CYC = 4000,
   parameter int SS_STEP_CYC = 1000,
   parameter int HI_CYC_100K = HI_CYC,
   parameter int LO_LIM = LO_CYC,
   parameter int OFF_LIM = OFF_CYC
) (
   input wire logic sys_clk,
   input wire logic srst,
   input wire reg_req_t reg_req,
   output logic [DW-1:0] reg_rdata,
   input wire sense_t sense,
   input wire logic pwm_request,
   output logic gate_drive_out,
   output logic hv_startup_en,
   output logic internal_supply_en,
   output logic softstart_bias_current,
   output logic thermal_shutdown_cleared,
   output logic [3:0] cs_setpoint_step,
   output logic irq
);
   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   state_t state_r, state_nxt;
   cause_t cause_r, cause_nxt;
   logic [1:0] ctrl_r, ctrl_nxt;
   logic [NEV-1:0] status_r, status_nxt;
   logic [NEV-1:0] mask_r, mask_nxt;
   logic [DW-1:0] rdata_r, rdata_nxt;
   logic [CW-1:0] ar_r, ar_nxt;
   logic [CW-1:0] ss_cnt_r, ss_cnt_nxt;
   logic [3:0] step_r, step_nxt;
   logic gate_r, gate_nxt;
   logic tsdc_r, tsdc_nxt;
   logic [NEV-1:0] trip;
   logic [NF-1:0] cond, fen, qual;
   logic active, opt_b, fast;

   assign active = (state_r == ST_SOFT) || (state_r == ST_RUN);
   assign opt_b = ctrl_r[CTRL_AUTOREC];
   assign fast = ctrl_r[CTRL_100K];

   // ----------------------------------------------------------------
   // Qualification filters
   // ----------------------------------------------------------------
   // Conditions and the windows in which each is allowed to count
   always_comb begin
      cond = '0;
      fen = '0;
      cond[F_FAULT] = sense.cs_at_limit | sense.max_duty_end;
      cond[F_UV] = sense.vcc_below_off;
      cond[F_EXT] = sense.ext_latch_req;
      cond[F_OVP] = sense.vcc_above_ovp;
      cond[F_TSD] = sense.thermal_shutdown;
      cond[F_OFF] = sense.feedback_below_off;
      cond[F_HI] = sense.latch_above_high;
      cond[F_LO] = sense.latch_below_low;
      fen[F_FAULT] = active;
      fen[F_UV] = active;
      fen[F_EXT] = active;
      fen[F_OVP] = active;
      fen[F_TSD] = active || (state_r == ST_IDLE);
      fen[F_OFF] = (state_r == ST_RUN);
      // Comparators settle only once the supply reached start
      fen[F_HI] = sense.vcc_above_start &&
         (active || (state_r == ST_IDLE));
      fen[F_LO] = (state_r == ST_RUN);
   end

   function automatic logic [CW-1:0] lim(input int i, input logic f);
      int v;
      v = QUAL_CYC;
      case (i)
         F_FAULT: v = FAULT_CYC;
         F_EXT: v = f ? EXT_CYC_100K : EXT_CYC_65K;
         F_OFF: v = OFF_LIM;
         F_HI: v = f ? HI_CYC_100K : HI_CYC;
         F_LO: v = LO_LIM;
         default: v = QUAL_CYC;
      endcase
      return CW'(v);
   endfunction : lim

   for (genvar i = 0; i < NF; i++) begin : g_flt
      logic [CW-1:0] cnt_r, cnt_nxt;
      // A drop of the condition restarts the count, so spikes vanish
      always_comb begin
         cnt_nxt = '0;
         if (cond[i] && fen[i]) begin
            if (cnt_r == lim(i, fast)) begin
               cnt_nxt = cnt_r;
            end else begin
               cnt_nxt = cnt_r + CW'(1);
            end
         end
      end
      always_ff @(posedge sys_clk) begin
         if (srst) begin
            cnt_r <= '0;
         end else begin
            cnt_r <= cnt_nxt;
         end
      end
      assign qual[i] = cond[i] && fen[i] && (cnt_r == lim(i, fast));
   end

   // ----------------------------------------------------------------
   // Protection state machine
   // ----------------------------------------------------------------
   always_comb begin
      state_nxt = state_r;
      cause_nxt = cause_r;
      ar_nxt = '0;
      ss_cnt_nxt = ss_cnt_r;
      step_nxt = step_r;
      trip = '0;
      case (state_r)
         ST_IDLE: begin
            ss_cnt_nxt = '0;
            step_nxt = '0;
            if (qual[F_TSD]) begin
               state_nxt = ST_TSD;
               trip[F_TSD] = 1'b1;
            end else if (qual[F_HI]) begin
               state_nxt = ST_LATCH;
               cause_nxt = C_PIN;
               trip[F_HI] = 1'b1;
            end else if (sense.vcc_above_start &&
                         !sense.latch_above_high) begin
               state_nxt = ST_SOFT;
            end
         end
         ST_SOFT, ST_RUN: begin
            if (state_r == ST_SOFT) begin
               // Setpoint climbs one step per step period
               if (ss_cnt_r == CW'(SS_STEP_CYC - 1)) begin
                  ss_cnt_nxt = '0;
                  step_nxt = step_r + 4'h1;
                  if (step_r == SS_LAST - 4'h1) begin
                     state_nxt = ST_RUN;
                  end
               end else begin
                  ss_cnt_nxt = ss_cnt_r + CW'(1);
               end
            end
            if (sense.cs_above_stop) begin
               state_nxt = ST_LATCH;
               cause_nxt = C_WS;
               trip[EV_WS] = 1'b1;
            end else if (qual[F_TSD]) begin
               state_nxt = ST_TSD;
               trip[F_TSD] = 1'b1;
            end else if (qual[F_UV]) begin
               state_nxt = ST_LATCH;
               cause_nxt = C_UV;
               trip[F_UV] = 1'b1;
            end else if (qual[F_OVP]) begin
               state_nxt = ST_LATCH;
               cause_nxt = C_OVP;
               trip[F_OVP] = 1'b1;
            end else if (qual[F_EXT]) begin
               state_nxt = ST_LATCH;
               cause_nxt = C_EXT;
               trip[F_EXT] = 1'b1;
            end else if (qual[F_HI] || qual[F_LO]) begin
               state_nxt = ST_LATCH;
               cause_nxt = C_PIN;
               trip[F_HI] = qual[F_HI];
               trip[F_LO] = qual[F_LO] && !qual[F_HI];
            end else if (qual[F_FAULT]) begin
               state_nxt = ST_LATCH;
               cause_nxt = C_FAULT;
               trip[F_FAULT] = 1'b1;
            end else if (qual[F_OFF]) begin
               state_nxt = ST_OFF;
               trip[F_OFF] = 1'b1;
            end
         end
         ST_LATCH: begin
            ss_cnt_nxt = '0;
            step_nxt = '0;
            // Autorecovery only after overcurrent or winding short
            if (opt_b && (cause_r == C_FAULT || cause_r == C_WS)) begin
               ar_nxt = ar_r + CW'(1);
            end
            if (sense.x2_discharge_done) begin
               state_nxt = ST_IDLE;
            end else if (cause_r == C_UV) begin
               if (!sense.vcc_below_reset) begin
                  state_nxt = ST_IDLE;
               end
            end else if (cause_r == C_EXT) begin
               if (!sense.vcc_above_start) begin
                  state_nxt = ST_IDLE;
               end
            end else if (sense.vcc_below_reset) begin
               state_nxt = ST_IDLE;
            end else if (ar_r == CW'(AUTOREC_CYC - 1)) begin
               state_nxt = ST_IDLE;
            end
            if (state_nxt == ST_IDLE) begin
               cause_nxt = C_NONE;
            end
         end
         ST_TSD: begin
            if (sense.vcc_above_start && !sense.thermal_shutdown) begin
               state_nxt = ST_SOFT;
               ss_cnt_nxt = '0;
               step_nxt = '0;
            end
         end
         ST_OFF: begin
            if (sense.vcc_above_start && sense.feedback_above_on) begin
               state_nxt = ST_SOFT;
               ss_cnt_nxt = '0;
               step_nxt = '0;
            end
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   // Gate drive follows the modulator only in soft-start and run
   always_comb begin
      gate_nxt = pwm_request && !sense.cs_above_stop &&
         ((state_nxt == ST_SOFT) || (state_nxt == ST_RUN));
      tsdc_nxt = !sense.thermal_shutdown;
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         state_r <= ST_IDLE;
         cause_r <= C_NONE;
         ar_r <= '0;
         ss_cnt_r <= '0;
         step_r <= '0;
         gate_r <= 1'b0;
         tsdc_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         cause_r <= cause_nxt;
         ar_r <= ar_nxt;
         ss_cnt_r <= ss_cnt_nxt;
         step_r <= step_nxt;
         gate_r <= gate_nxt;
         tsdc_r <= tsdc_nxt;
      end
   end

   assign gate_drive_out = gate_r;
   assign cs_setpoint_step = (state_r == ST_RUN) ? SS_LAST : step_r;
   assign softstart_bias_current = (state_r == ST_SOFT);
   assign hv_startup_en = (state_r != ST_TSD);
   // Shutdown keeps the supply so the thermal event stays remembered
   assign internal_supply_en = (state_r != ST_OFF);
   assign thermal_shutdown_cleared = tsdc_r;

   // ----------------------------------------------------------------
   // Register port and interrupt
   // ----------------------------------------------------------------
   always_comb begin
      ctrl_nxt = ctrl_r;
      mask_nxt = mask_r;
      status_nxt = status_r;
      rdata_nxt = '0;
      if (reg_req.wr) begin
         if (reg_req.addr == REG_CTRL) begin
            ctrl_nxt = reg_req.wdata[1:0];
         end else if (reg_req.addr == REG_MASK) begin
            mask_nxt = reg_req.wdata[NEV-1:0];
         end else if (reg_req.addr == REG_STATUS) begin
            status_nxt = status_r & ~reg_req.wdata[NEV-1:0];
         end
      end
      // A new event wins over a clear in the same cycle
      status_nxt = status_nxt | trip;
      if (reg_req.rd) begin
         if (reg_req.addr == REG_CTRL) begin
            rdata_nxt = {14'h0000, ctrl_r};
         end else if (reg_req.addr == REG_STATUS) begin
            rdata_nxt = {7'h00, status_r};
         end else if (reg_req.addr == REG_MASK) begin
            rdata_nxt = {7'h00, mask_r};
         end else begin
            rdata_nxt = {5'h00, tsdc_r, step_r, cause_r, state_r};
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         ctrl_r <= CTRL_RST;
         mask_r <= MASK_RST;
         status_r <= '0;
         rdata_r <= '0;
      end else begin
         ctrl_r <= ctrl_nxt;
         mask_r <= mask_nxt;
         status_r <= status_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   assign reg_rdata = rdata_r;
   assign irq = |(status_r & mask_r);

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);

   sequence short_in_run;
      active && sense.cs_above_stop;
   endsequence
   sequence latched_now;
      (state_r == ST_LATCH) && (cause_r == C_WS) && !gate_r;
   endsequence
   sequence latch_x2;
      (state_r == ST_LATCH) && sense.x2_discharge_done;
   endsequence

   short_latch_a: assert property (short_in_run |=> latched_now)
      else $error("winding short did not latch at once");
   x2_release_a: assert property (latch_x2 |=> state_r == ST_IDLE)
      else $error("X2 discharge did not release the latch");
   gate_low_a: assert property (!active |-> !gate_drive_out)
      else $error("gate driven while stopped");
   uv_qual_a: assert property ($rose(qual[F_UV]) |->
      $past(g_flt[F_UV].cnt_r) == CW'(QUAL_CYC - 1))
      else $error("supply low qualified with wrong time");
   fault_restart_a: assert property (active && !sense.cs_at_limit &&
      !sense.max_duty_end |=> g_flt[F_FAULT].cnt_r == '0)
      else $error("fault timer did not restart");
   lo_gated_a: assert property (state_r == ST_SOFT |->
      g_flt[F_LO].cnt_r == '0)
      else $error("low latch counted during soft-start");
   tsd_hv_a: assert property ((state_r == ST_TSD) |->
      !hv_startup_en && internal_supply_en)
      else $error("shutdown left start-up source on");
   off_supply_a: assert property ($rose(state_r == ST_OFF) |->
      !internal_supply_en && $past(qual[F_OFF]))
      else $error("off mode entered without qualified feedback");
   ss_bias_a: assert property (softstart_bias_current ==
      (state_r == ST_SOFT))
      else $error("bias doubling outside soft-start");
   ss_done_a: assert property ($rose(state_r == ST_RUN) &&
      $past(state_r) == ST_SOFT |-> $past(step_r) == 4'he)
      else $error("soft-start ended after wrong step count");
endmodule : protection_latch_supervisor

// [pkg/latch_sup_pkg.sv]
// Constants, types and register map of the protection latch supervisor
package latch_sup_pkg;
   // ----------------------------------------------------------------
   // Clock and timing
   // ----------------------------------------------------------------
   localparam int CLK_HZ = 25_000_000;
   localparam int CYC_PER_US = CLK_HZ / 1_000_000;
   localparam int CYC_PER_MS = CLK_HZ / 1_000;
   localparam int QUAL_US = 10;
   localparam int EXT_US_65K = 55;
   localparam int EXT_US_100K = 35;
   localparam int HI_US = 50;
   localparam int LO_US = 350;
   localparam int OFF_MS = 600;
   localparam int QUAL_CYC = QUAL_US * CYC_PER_US;
   localparam int EXT_CYC_65K = EXT_US_65K * CYC_PER_US;
   localparam int EXT_CYC_100K = EXT_US_100K * CYC_PER_US;
   localparam int HI_CYC = HI_US * CYC_PER_US;
   localparam int LO_CYC = LO_US * CYC_PER_US;
   localparam int OFF_CYC = OFF_MS * CYC_PER_MS;
   localparam int CW = 24;
   localparam logic [3:0] SS_LAST = 4'hf;
   // ----------------------------------------------------------------
   // Qualification filters and events
   // ----------------------------------------------------------------
   localparam int NF = 8;
   localparam int F_FAULT = 0;
   localparam int F_UV = 1;
   localparam int F_EXT = 2;
   localparam int F_OVP = 3;
   localparam int F_TSD = 4;
   localparam int F_OFF = 5;
   localparam int F_HI = 6;
   localparam int F_LO = 7;
   localparam int EV_WS = 8;
   localparam int NEV = 9;
   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam int AW = 2;
   localparam int DW = 16;
   localparam logic [1:0] REG_CTRL = 2'h0;
   localparam logic [1:0] REG_STATUS = 2'h1;
   localparam logic [1:0] REG_MASK = 2'h2;
   localparam logic [1:0] REG_STATE = 2'h3;
   localparam logic [1:0] CTRL_RST = 2'h0;
   localparam logic [NEV-1:0] MASK_RST = 9'h000;
   localparam int CTRL_AUTOREC = 0;
   localparam int CTRL_100K = 1;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_SOFT = 3'b001,
      ST_RUN = 3'b010,
      ST_LATCH = 3'b011,
      ST_TSD = 3'b100,
      ST_OFF = 3'b101
   } state_t;

   typedef enum logic [2:0] {
      C_NONE = 3'b000,
      C_FAULT = 3'b001,
      C_WS = 3'b010,
      C_UV = 3'b011,
      C_EXT = 3'b100,
      C_OVP = 3'b101,
      C_PIN = 3'b110
   } cause_t;

   typedef struct packed {
      logic cs_at_limit;
      logic max_duty_end;
      logic cs_above_stop;
      logic vcc_below_off;
      logic vcc_below_reset;
      logic vcc_above_start;
      logic vcc_above_ovp;
      logic ext_latch_req;
      logic latch_above_high;
      logic latch_below_low;
      logic thermal_shutdown;
      logic feedback_below_off;
      logic feedback_above_on;
      logic x2_discharge_done;
   } sense_t;

   typedef struct packed {
      logic [AW-1:0] addr;
      logic [DW-1:0] wdata;
      logic wr;
      logic rd;
   } reg_req_t;
endpackage : latch_sup_pkg

// [verif/power_stage_model.sv]
// Behavioural model of the power stage, supply comparators and sensors
module power_stage_model
   import latch_sup_pkg::*;
(
   input wire logic sys_clk,
   input wire logic [13:0] extra,
   input wire logic [1:0] vcc_mode,
   output sense_t sense,
   output logic pwm_request
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------------------------------
   // Supply comparators
   // ----------------------------------------------------------------
   // Modes: 0 below reset, 1 below turn-off, 2 normal, 3 over-voltage.
   // The comparator outputs are derived together so they never disagree.
   always_comb begin
      sense = sense_t'(extra);
      sense.vcc_below_reset = (vcc_mode == 2'h0);
      sense.vcc_below_off = (vcc_mode < 2'h2);
      sense.vcc_above_start = (vcc_mode >= 2'h2);
      sense.vcc_above_ovp = (vcc_mode == 2'h3);
   end
   // ----------------------------------------------------------------
   // Modulator
   // ----------------------------------------------------------------
   logic pwm_r = 1'b0;
   // Toggles every cycle so a stuck or late gate shows at once
   always @(posedge sys_clk) begin
      pwm_r <= !pwm_r;
   end
   assign pwm_request = pwm_r;
endmodule : power_stage_model

// [verif/testbench.sv]
// Self-checking bench of the protection latch supervisor
module testbench
   import latch_sup_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   localparam int FC = 20;
   localparam int AR = 40;
   localparam int SS = 4;
   localparam int LO = 30;
   localparam int OF = 50;
   localparam logic [13:0] S_CSL = 14'h2000, S_MDE = 14'h1000,
      S_WS = 14'h0800, S_EXT = 14'h0040, S_HI = 14'h0020, S_LO = 14'h0010,
      S_TSD = 14'h0008, S_FBL = 14'h0004, S_FBH = 14'h0002, S_X2 = 14'h0001;
   logic sys_clk = 1'b0;
   logic srst = 1'b1;
   reg_req_t req;
   logic [DW-1:0] rdata;
   sense_t sense;
   logic pwm, gate, hv, isup, bias, tsdc, irq;
   logic [3:0] step;
   logic [13:0] extra;
   logic [1:0] vmode;
   int err_total = 0;
   int checked = 0;
   always #20 sys_clk = ~sys_clk;
   protection_latch_supervisor #(.FAULT_CYC(FC), .AUTOREC_CYC(AR),
      .SS_STEP_CYC(SS), .LO_LIM(LO), .OFF_LIM(OF))
   u_protection_latch_supervisor (.sys_clk(sys_clk), .srst(srst),
      .reg_req(req), .reg_rdata(rdata), .sense(sense), .pwm_request(pwm),
      .gate_drive_out(gate), .hv_startup_en(hv), .internal_supply_en(isup),
      .softstart_bias_current(bias), .thermal_shutdown_cleared(tsdc),
      .cs_setpoint_step(step), .irq(irq));
   power_stage_model u_power_stage_model (.sys_clk(sys_clk), .extra(extra),
      .vcc_mode(vmode), .sense(sense), .pwm_request(pwm));
   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic complete_run;
      $display("Counts: %0d checked, %0d mismatches", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : complete_run
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR at %0t: word %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic chk1(input logic got, input logic exp);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR at %0t: bit %b expected %b", $time, got, exp);
      end
   endtask : chk1
   task automatic wr_reg(input logic [1:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      req.addr <= a;
      req.wdata <= d;
      req.wr <= 1'b1;
      @(posedge sys_clk);
      req.wr <= 1'b0;
   endtask : wr_reg
   task automatic rd_reg(input logic [1:0] a, output logic [15:0] d);
      @(posedge sys_clk);
      req.addr <= a;
      req.rd <= 1'b1;
      @(posedge sys_clk);
      req.rd <= 1'b0;
      @(negedge sys_clk);
      d = rdata;
   endtask : rd_reg
   task automatic expect_state(input state_t s);
      logic [15:0] d;
      rd_reg(REG_STATE, d);
      chk({13'h0, d[2:0]}, {13'h0, s});
   endtask : expect_state
   task automatic st_bit(input int i, input logic v);
      logic [15:0] d;
      rd_reg(REG_STATUS, d);
      chk1(d[i], v);
   endtask : st_bit
   task automatic drive(input logic [13:0] m, input logic [1:0] v,
      input int n);
      @(posedge sys_clk);
      extra <= m;
      vmode <= v;
      repeat (n) @(posedge sys_clk);
   endtask : drive
   task automatic hold(input logic [13:0] m, input logic [1:0] v,
      input int n);
      drive(m, v, n);
      drive(14'h0, 2'h2, 0);
   endtask : hold
   // Bounded wait for a completed start-up
   task automatic to_run;
      logic [15:0] d;
      for (int i = 0; i < 80; i++) begin
         rd_reg(REG_STATE, d);
         if (d[2:0] === ST_RUN) return;
      end
      err_total++;
      $display("ERROR at %0t: no start-up seen", $time);
      complete_run();
   endtask : to_run
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_start;
      logic [15:0] d;
      rd_reg(REG_MASK, d);
      chk(d, {7'h0, MASK_RST});
      rd_reg(REG_CTRL, d);
      chk(d, {14'h0, CTRL_RST});
      chk1(bias, 1'b1);
      chk1(step < 4'hf, 1'b1);
      to_run();
      @(negedge sys_clk);
      chk({12'h0, step}, {12'h0, SS_LAST});
      chk1(bias, 1'b0);
      chk1(gate, !pwm);
      $display("t_start done");
   endtask : t_start
   task automatic t_fault;
      hold(S_CSL, 2'h2, FC - 2);
      hold(S_MDE, 2'h2, FC - 2);
      expect_state(ST_RUN);
      hold(S_MDE, 2'h2, FC + 4);
      expect_state(ST_LATCH);
      repeat (4) begin
         @(negedge sys_clk);
         chk1(gate, 1'b0);
      end
      st_bit(F_FAULT, 1'b1);
      wr_reg(REG_MASK, 16'h0001);
      @(negedge sys_clk);
      chk1(irq, 1'b1);
      wr_reg(REG_STATUS, 16'h0001);
      @(negedge sys_clk);
      chk1(irq, 1'b0);
      wr_reg(REG_MASK, 16'h0000);
      hold(S_X2, 2'h2, 1);
      expect_state(ST_SOFT);
      to_run();
      $display("t_fault done");
   endtask : t_fault
   task automatic t_auto_ws;
      wr_reg(REG_CTRL, 16'h0001);
      hold(S_CSL, 2'h2, FC + 4);
      expect_state(ST_LATCH);
      repeat (AR + 10) @(posedge sys_clk);
      expect_state(ST_SOFT);
      wr_reg(REG_CTRL, 16'h0000);
      to_run();
      hold(S_WS, 2'h2, 1);
      @(negedge sys_clk);
      chk1(gate, 1'b0);
      repeat (AR + 10) @(posedge sys_clk);
      expect_state(ST_LATCH);
      hold(14'h0, 2'h0, 2);
      to_run();
      $display("t_auto_ws done");
   endtask : t_auto_ws
   task automatic t_supply;
      hold(14'h0, 2'h1, QUAL_CYC - 2);
      st_bit(F_UV, 1'b0);
      hold(14'h0, 2'h1, QUAL_CYC + 4);
      st_bit(F_UV, 1'b1);
      to_run();
      hold(14'h0, 2'h3, QUAL_CYC + 4);
      repeat (20) @(posedge sys_clk);
      expect_state(ST_LATCH);
      hold(14'h0, 2'h0, 2);
      to_run();
      $display("t_supply done");
   endtask : t_supply
   task automatic t_ext;
      hold(S_EXT, 2'h2, EXT_CYC_65K + 4);
      expect_state(ST_LATCH);
      hold(14'h0, 2'h1, 3);
      to_run();
      wr_reg(REG_CTRL, 16'h0002);
      hold(S_EXT, 2'h2, EXT_CYC_100K - 2);
      expect_state(ST_RUN);
      hold(S_EXT, 2'h2, EXT_CYC_100K + 4);
      expect_state(ST_LATCH);
      hold(S_X2, 2'h2, 1);
      wr_reg(REG_CTRL, 16'h0000);
      to_run();
      $display("t_ext done");
   endtask : t_ext
   task automatic t_pin;
      hold(S_HI, 2'h2, HI_CYC - 2);
      expect_state(ST_RUN);
      hold(S_HI, 2'h2, HI_CYC + 4);
      expect_state(ST_LATCH);
      // High pin below start must neither count nor let the start go on
      drive(S_X2 | S_HI, 2'h1, HI_CYC + 4);
      drive(S_HI, 2'h2, 4);
      expect_state(ST_IDLE);
      hold(S_LO, 2'h2, LO + 10);
      expect_state(ST_SOFT);
      to_run();
      hold(S_LO, 2'h2, LO + 4);
      expect_state(ST_LATCH);
      hold(S_X2, 2'h2, 1);
      to_run();
      $display("t_pin done");
   endtask : t_pin
   task automatic t_tsd;
      drive(S_TSD, 2'h2, QUAL_CYC + 4);
      @(negedge sys_clk);
      chk1(hv, 1'b0);
      chk1(gate, 1'b0);
      chk1(isup, 1'b1);
      chk1(tsdc, 1'b0);
      expect_state(ST_TSD);
      drive(14'h0, 2'h2, 3);
      @(negedge sys_clk);
      chk1(tsdc, 1'b1);
      to_run();
      $display("t_tsd done");
   endtask : t_tsd
   task automatic t_off;
      drive(S_FBL, 2'h2, OF + 4);
      @(negedge sys_clk);
      chk1(isup, 1'b0);
      drive(14'h0, 2'h2, 5);
      expect_state(ST_OFF);
      drive(S_FBH, 2'h2, 3);
      to_run();
      drive(14'h0, 2'h2, 0);
      $display("t_off done");
   endtask : t_off
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      req = '0;
      extra = 14'h0;
      vmode = 2'h2;
      repeat (4) @(posedge sys_clk);
      srst <= 1'b0;
      t_start();
      t_fault();
      t_auto_ws();
      t_supply();
      t_ext();
      t_pin();
      t_tsd();
      t_off();
      complete_run();
   end
endmodule : testbench
